// ==== core/etw_prescaler.v ====
// Purpose: free running 10-bit prescaler giving the timer clock enable
// Assumes: one clock; clock select 0 stops the timer
// Notes: the enable is a one-cycle pulse on CLK for selects 2 to 7, held high on every cycle for select 1
`timescale 1ns/1ps
`include "etw_regs.vh"

module etw_prescaler #(
	parameter PRE_W = 10
) (
	input wire clk,
	input wire resetn,
	input wire [2:0] clock_select_field,
	output wire timer_clock_enable
);
	reg [PRE_W-1:0] pre_count;
	reg [PRE_W-1:0] mask;

	always @(posedge clk) begin
		if (!resetn) begin
			pre_count <= {PRE_W{1'b0}};
		end else begin
			pre_count <= pre_count + {{(PRE_W-1){1'b0}}, 1'b1};
		end
	end

	always @* begin
		case (clock_select_field)
		3'h2: mask = `ETW_DIV8;
		3'h3: mask = `ETW_DIV32;
		3'h4: mask = `ETW_DIV64;
		3'h5: mask = `ETW_DIV128;
		3'h6: mask = `ETW_DIV256;
		3'h7: mask = `ETW_DIV1024;
		default: mask = {PRE_W{1'b0}};
		endcase
	end

	// divider taps share one counter so every rate stays phase aligned
	assign timer_clock_enable = (clock_select_field != 3'h0) && ((pre_count & mask) == mask);
endmodule

// ==== core/etw_regs.vh ====
// Purpose: register offsets, field positions, reset values and timing counts for the 8-bit timer
// Assumes: APB byte addresses, one 32-bit aligned word per register
// Notes: included by the timer core and its prescaler
`ifndef ETW_REGS_VH
`define ETW_REGS_VH

`define ETW_ADDR_W 8
`define ETW_OFF_CONTROL 8'h00
`define ETW_OFF_COUNT 8'h04
`define ETW_OFF_COMPARE 8'h08
`define ETW_OFF_STATUS 8'h0C
`define ETW_OFF_MASK 8'h10
`define ETW_OFF_PORT 8'h14

`define ETW_CTL_FORCE 7
`define ETW_CTL_WGM_LOW 6
`define ETW_CTL_COM_HIGH 5
`define ETW_CTL_COM_LOW 4
`define ETW_CTL_WGM_HIGH 3
`define ETW_CTL_CS_MSB 2
`define ETW_CTL_RESET 8'h00

`define ETW_ST_OVF 0
`define ETW_ST_CMP 1

`define ETW_PORT_DIR 0
`define ETW_PORT_DATA 1

`define ETW_MODE_NORMAL 2'h0
`define ETW_MODE_PCPWM 2'h1
`define ETW_MODE_CTC 2'h2
`define ETW_MODE_FPWM 2'h3

`define ETW_MAX 8'hFF
`define ETW_BOTTOM 8'h00

`define ETW_DIV8 10'h007
`define ETW_DIV32 10'h01F
`define ETW_DIV64 10'h03F
`define ETW_DIV128 10'h07F
`define ETW_DIV256 10'h0FF
`define ETW_DIV1024 10'h3FF

`endif

// ==== core/etw_timer.v ====
// Purpose: 8-bit timer with one compare channel, four waveform modes and an APB slave
// Assumes: CLK is the I/O clock; the timer clock is an enable from the prescaler
// Notes: interrupt output high while an unmasked sticky flag is set
//
// How it works
// RULE1: writing force bit in non-PWM mode applies a compare match to the output
// RULE2: forced match sets no flag and never clears the counter
// RULE3: force bit is a strobe and always reads zero
// RULE4: software writes force bit as zero while in a PWM mode
// RULE5: mode 0 normal, 1 phase correct, 2 clear-on-compare, 3 fast; top 0xFF or compare
// RULE6: compare buffer immediate in non-PWM, at top in PWM; overflow at MAX or BOTTOM
// RULE7: nonzero output mode overrides port; pin driven only when direction is output
// RULE8: non-PWM output mode: off, toggle, clear, set on match
// RULE9: fast PWM: off, reserved, clear on match set at top, or inverse
// RULE10: phase correct: clear on up match set on down match, or inverse
// RULE11: PWM with compare equal top and high mode bit ignores match, top action kept
// RULE12: clock select stops, passes undivided, or divides by 8 to 1024
// RULE13: counter is readable and writable; a write replaces the count
// RULE14: counter write blocks the compare match on the next timer clock
// RULE15: compare checked every timer clock; match sets flag and drives output
// RULE16: timer clock is an enable in the I/O clock domain
// RULE17: control register resets to zero: stopped, normal, disconnected
// RULE18: fast PWM counts and flags only on enable cycles, wrapping MAX to BOTTOM
// RULE19: fast counts up and restarts; phase correct goes up then down
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "etw_regs.vh"

module etw_timer (
	input wire CLK,
	input wire RESETN,
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [7:0] PADDR,
	input wire [31:0] PWDATA,
	output reg [31:0] PRDATA,
	output reg PREADY,
	output reg PSLVERR,
	input wire PORT_IN,
	output reg COMPARE_OUTPUT_PIN,
	output reg COMPARE_OUTPUT_PIN_OE,
	output reg IRQ
);
	reg [7:0] timer_control_a;
	reg [7:0] timer_count_value;
	reg [7:0] compare_value_a;
	reg [7:0] compare_buffer;
	reg [1:0] status;
	reg [1:0] mask;
	reg [1:0] port_ctl;
	reg count_down;
	reg block_match;
	reg oc_level;
	reg port_sync1;
	reg port_sync2;
	reg next_oc;
	reg [7:0] next_count;
	reg next_down;
	reg [1:0] set_ev;

	wire timer_clock_enable;
	wire [1:0] waveform_mode_field;
	wire [1:0] compare_output_mode_field;
	wire compare_output_mode_high;
	wire is_pwm;
	wire [7:0] top;
	wire bus_access;
	wire bus_wr;
	wire force_compare_strobe;
	wire [1:0] force_com;
	wire raw_match;
	wire match_en;

	assign waveform_mode_field = {timer_control_a[`ETW_CTL_WGM_HIGH], timer_control_a[`ETW_CTL_WGM_LOW]};
	assign compare_output_mode_field = timer_control_a[`ETW_CTL_COM_HIGH:`ETW_CTL_COM_LOW];
	assign compare_output_mode_high = timer_control_a[`ETW_CTL_COM_HIGH];
	assign is_pwm = waveform_mode_field[0]; // [RULE5]
	assign top = (waveform_mode_field == `ETW_MODE_CTC) ? compare_value_a : `ETW_MAX; // [RULE5]

	assign bus_access = PSEL && PENABLE && !PREADY;
	assign bus_wr = bus_access && PWRITE;
	// the strobe is decoded from the write itself, never stored [RULE3]
	// mode and output mode come from the same write, so one write can both set them and force
	assign force_com = PWDATA[`ETW_CTL_COM_HIGH:`ETW_CTL_COM_LOW];
	assign force_compare_strobe = bus_wr && (PADDR == `ETW_OFF_CONTROL) && PWDATA[`ETW_CTL_FORCE]
		&& !PWDATA[`ETW_CTL_WGM_LOW]; // [RULE1]

	etw_prescaler #(
		.PRE_W(10)
	) u_pre (
		.clk(CLK),
		.resetn(RESETN),
		.clock_select_field(timer_control_a[`ETW_CTL_CS_MSB:0]),
		.timer_clock_enable(timer_clock_enable)
	); // [RULE12] [RULE16]

	// compare uses the active value: buffered copy in PWM modes
	assign raw_match = timer_count_value == compare_value_a;
	// PWM with compare at top and high mode bit: match ignored [RULE11]
	assign match_en = timer_clock_enable && raw_match && !block_match
		&& !(is_pwm && compare_output_mode_high && compare_value_a == top); // [RULE14] [RULE15]

	// counter sequencing [RULE18] [RULE19]
	always @* begin
		next_count = timer_count_value;
		next_down = count_down;
		set_ev = 2'h0;
		case (waveform_mode_field)
		`ETW_MODE_PCPWM: begin
			if (!count_down) begin
				if (timer_count_value == `ETW_MAX) begin
					next_down = 1'b1;
					next_count = timer_count_value - 8'h01;
				end else begin
					next_count = timer_count_value + 8'h01;
				end
			end else begin
				if (timer_count_value == `ETW_BOTTOM) begin
					next_down = 1'b0;
					next_count = timer_count_value + 8'h01;
					set_ev[`ETW_ST_OVF] = 1'b1; // [RULE6]
				end else begin
					next_count = timer_count_value - 8'h01;
				end
			end
		end
		`ETW_MODE_CTC: begin
			next_down = 1'b0;
			// forced strobes never reach this clear [RULE2]
			if (raw_match && !block_match) begin
				next_count = `ETW_BOTTOM;
			end else begin
				next_count = timer_count_value + 8'h01;
			end
			if (timer_count_value == `ETW_MAX) begin
				set_ev[`ETW_ST_OVF] = 1'b1; // [RULE6]
			end
		end
		default: begin
			next_down = 1'b0;
			next_count = timer_count_value + 8'h01; // wraps MAX to BOTTOM [RULE18]
			if (timer_count_value == `ETW_MAX) begin
				set_ev[`ETW_ST_OVF] = 1'b1; // [RULE6]
			end
		end
		endcase
		if (match_en) begin
			set_ev[`ETW_ST_CMP] = 1'b1; // [RULE15]
		end
	end

	// waveform generator
	always @* begin
		next_oc = oc_level;
		if (force_compare_strobe) begin // [RULE1] [RULE8]
			case (force_com)
			2'h1: next_oc = !oc_level;
			2'h2: next_oc = 1'b0;
			2'h3: next_oc = 1'b1;
			default: next_oc = oc_level;
			endcase
		end else if (!is_pwm) begin
			if (match_en) begin // [RULE8]
				case (compare_output_mode_field)
				2'h1: next_oc = !oc_level;
				2'h2: next_oc = 1'b0;
				2'h3: next_oc = 1'b1;
				default: next_oc = oc_level;
				endcase
			end
		end else if (waveform_mode_field == `ETW_MODE_FPWM) begin
			if (timer_clock_enable && compare_output_mode_high) begin // [RULE9]
				if (timer_count_value == `ETW_MAX) begin
					next_oc = !compare_output_mode_field[0];
				end else if (match_en) begin
					next_oc = compare_output_mode_field[0];
				end
			end
		end else begin
			if (timer_clock_enable && compare_output_mode_high) begin // [RULE10]
				if (compare_value_a == `ETW_MAX && timer_count_value == `ETW_MAX) begin
					// at top the level matches an up-count match [RULE11]
					next_oc = compare_output_mode_field[0];
				end else if (match_en) begin
					next_oc = count_down ? !compare_output_mode_field[0] : compare_output_mode_field[0];
				end
			end
		end
	end

	always @(posedge CLK) begin
		if (!RESETN) begin
			timer_control_a <= `ETW_CTL_RESET; // [RULE17]
			timer_count_value <= 8'h00;
			compare_value_a <= 8'h00;
			compare_buffer <= 8'h00;
			status <= 2'h0;
			mask <= 2'h0;
			port_ctl <= 2'h0;
			count_down <= 1'b0;
			block_match <= 1'b0;
			oc_level <= 1'b0;
			port_sync1 <= 1'b0;
			port_sync2 <= 1'b0;
			PRDATA <= 32'h0000_0000;
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			COMPARE_OUTPUT_PIN <= 1'b0;
			COMPARE_OUTPUT_PIN_OE <= 1'b0;
			IRQ <= 1'b0;
		end else begin
			port_sync1 <= PORT_IN;
			port_sync2 <= port_sync1;
			oc_level <= next_oc;
			PREADY <= bus_access;
			PSLVERR <= 1'b0;
			if (timer_clock_enable) begin
				timer_count_value <= next_count;
				count_down <= next_down;
				block_match <= 1'b0;
				// PWM modes load the buffered compare value at top [RULE6]
				if (is_pwm && timer_count_value == `ETW_MAX) begin
					compare_value_a <= compare_buffer;
				end
			end
			// set wins over a write-one clear
			status <= (status & ~((bus_wr && PADDR == `ETW_OFF_STATUS) ? PWDATA[1:0] : 2'h0))
				| (timer_clock_enable ? set_ev : 2'h0); // [RULE2] [RULE6] [RULE15]
			if (bus_wr) begin
				case (PADDR)
				`ETW_OFF_CONTROL: timer_control_a <= {1'b0, PWDATA[6:0]}; // [RULE3] [RULE5] [RULE12]
				`ETW_OFF_COUNT: begin
					timer_count_value <= PWDATA[7:0]; // [RULE13]
					block_match <= 1'b1; // [RULE14]
				end
				`ETW_OFF_COMPARE: begin
					compare_buffer <= PWDATA[7:0];
					if (!is_pwm) begin
						compare_value_a <= PWDATA[7:0]; // [RULE6]
					end
				end
				`ETW_OFF_MASK: mask <= PWDATA[1:0];
				`ETW_OFF_PORT: port_ctl <= PWDATA[1:0];
				default: PSLVERR <= (PADDR != `ETW_OFF_STATUS);
				endcase
			end
			if (bus_access && !PWRITE) begin
				case (PADDR)
				`ETW_OFF_CONTROL: PRDATA <= {24'h00_0000, 1'b0, timer_control_a[6:0]}; // [RULE3]
				`ETW_OFF_COUNT: PRDATA <= {24'h00_0000, timer_count_value}; // [RULE13]
				`ETW_OFF_COMPARE: PRDATA <= {24'h00_0000, is_pwm ? compare_buffer : compare_value_a};
				`ETW_OFF_STATUS: PRDATA <= {30'h0000_0000, status};
				`ETW_OFF_MASK: PRDATA <= {30'h0000_0000, mask};
				`ETW_OFF_PORT: PRDATA <= {29'h0000_0000, port_sync2, port_ctl};
				default: begin
					PRDATA <= 32'h0000_0000;
					PSLVERR <= 1'b1;
				end
				endcase
			end
			// override when any mode bit set; drive only if direction is output [RULE7]
			COMPARE_OUTPUT_PIN <= (compare_output_mode_field != 2'h0) ? next_oc : port_ctl[`ETW_PORT_DATA];
			COMPARE_OUTPUT_PIN_OE <= port_ctl[`ETW_PORT_DIR];
			IRQ <= |(status & mask);
		end
	end
endmodule

// ==== verification/etw_timer_chk.sv ====
// Purpose: bus and pin checks on the timer's top-level ports
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every instance of the timer
`timescale 1ns/1ps
`include "etw_regs.vh"
module etw_timer_chk (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic PORT_IN,
	input wire logic COMPARE_OUTPUT_PIN,
	input wire logic COMPARE_OUTPUT_PIN_OE,
	input wire logic IRQ
);
	default clocking dc @(posedge CLK); endclocking
	default disable iff (!RESETN);
	sequence taken;
		PSEL && PENABLE && !PREADY;
	endsequence
	sequence rd_ctl;
		taken ##0 (!PWRITE && PADDR == `ETW_OFF_CONTROL);
	endsequence
	sequence port_wr;
		taken ##0 (PWRITE && PADDR == `ETW_OFF_PORT);
	endsequence
	ready_next_a: assert property (taken |=> PREADY) else $error("ready late");
	ready_pulse_a: assert property (PREADY |=> !PREADY) else $error("ready too long");
	err_with_ready_a: assert property (PSLVERR |-> PREADY) else $error("error without ready");
	err_unmapped_a: assert property (taken ##0 PADDR > 8'h14 |=> PSLVERR) else $error("no error");
	err_mapped_a: assert property (taken ##0 PADDR[1:0] == 2'h0 && PADDR <= 8'h14 |=> !PSLVERR)
		else $error("spurious error");
	upper_zero_a: assert property (taken ##0 !PWRITE |=> PRDATA[31:8] == 24'h00_0000) else $error("upper bits");
	strobe_reads_zero_a: assert property (rd_ctl |=> !PRDATA[7]) else $error("strobe read one");
	oe_follows_a: assert property (port_wr ##0 PWDATA[0] |-> ##[1:2] COMPARE_OUTPUT_PIN_OE)
		else $error("no drive");
	reset_clear_a: assert property ($rose(RESETN) |-> !PREADY && !IRQ && !COMPARE_OUTPUT_PIN_OE)
		else $error("outputs after reset");
endmodule
bind etw_timer etw_timer_chk chk_i (.CLK(CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.PORT_IN(PORT_IN), .COMPARE_OUTPUT_PIN(COMPARE_OUTPUT_PIN), .COMPARE_OUTPUT_PIN_OE(COMPARE_OUTPUT_PIN_OE),
	.IRQ(IRQ));

// ==== verification/tb.sv ====
// Purpose: register-level tests of the timer over its bus
// Assumes: one wait state bus slave
// Notes: count figures in the divider loop carry slack for the free running prescaler phase
`timescale 1ns/1ps
`include "etw_regs.vh"
module tb;
	logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, pin_in = 0, rerr;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic pready, pslverr, pin, oe, irq;
	int err_count = 0, compares = 0, cyc = 0, hi;
	int divs[6] = '{8, 32, 64, 128, 256, 1024};
	always #50 clk = ~clk;
	etw_timer DUT (.CLK(clk), .RESETN(rstn), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PORT_IN(pin_in),
		.COMPARE_OUTPUT_PIN(pin), .COMPARE_OUTPUT_PIN_OE(oe), .IRQ(irq));
	task final_report;
		if (err_count == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_count++;
			final_report;
		end
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// one wait state is expected, but the loop lets the global timeout judge a hang
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		paddr <= a;
		pwr <= w;
		pwdata <= d;
		@(posedge clk);
		pen <= 1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		rerr = pslverr;
		psel <= 0;
		pen <= 0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1, d);
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e);
		apb(a, 0, 0);
		chk(rd, e);
	endtask
	function logic [31:0] ctl(input logic [1:0] m, input logic [1:0] com, input logic [2:0] cs, input logic f);
		return {24'h00_0000, f, m[0], com, m[1], cs};
	endfunction
	initial begin
		repeat (8) @(posedge clk);
		rstn <= 1;
		rdc(`ETW_OFF_CONTROL, 0);
		rdc(`ETW_OFF_STATUS, 0);
		wr(`ETW_OFF_COUNT, 32'h0000_005A);
		rdc(`ETW_OFF_COUNT, 32'h0000_005A);
		rdc(8'h18, 0);
		chk(rerr, 1);
		wr(`ETW_OFF_PORT, 1);
		// toggle from low, then clear, then set
		for (int i = 1; i < 4; i++) begin
			wr(`ETW_OFF_CONTROL, ctl(0, i, 0, 1));
			repeat (3) @(posedge clk);
			chk(pin, i != 2);
			chk(oe, 1);
		end
		rdc(`ETW_OFF_CONTROL, 32'h0000_0030);
		rdc(`ETW_OFF_STATUS, 0);
		// strobe written in fast mode on purpose: it must change nothing
		wr(`ETW_OFF_CONTROL, ctl(3, 2, 0, 1));
		repeat (3) @(posedge clk);
		chk(pin, 1);
		wr(`ETW_OFF_CONTROL, 0);
		wr(`ETW_OFF_MASK, 3);
		wr(`ETW_OFF_COMPARE, 5);
		wr(`ETW_OFF_COUNT, 0);
		wr(`ETW_OFF_CONTROL, ctl(2, 0, 1, 0));
		repeat (40) @(posedge clk);
		wr(`ETW_OFF_CONTROL, 0);
		apb(`ETW_OFF_COUNT, 0, 0);
		chk(rd <= 5, 1);
		rdc(`ETW_OFF_STATUS, 2);
		chk(irq, 1);
		wr(`ETW_OFF_STATUS, 3);
		repeat (3) @(posedge clk);
		chk(irq, 0);
		wr(`ETW_OFF_COMPARE, 32'h0000_0080);
		wr(`ETW_OFF_COUNT, 32'h0000_00F0);
		wr(`ETW_OFF_CONTROL, ctl(0, 0, 1, 0));
		repeat (25) @(posedge clk);
		wr(`ETW_OFF_CONTROL, 0);
		rdc(`ETW_OFF_STATUS, 1);
		wr(`ETW_OFF_STATUS, 3);
		for (int i = 0; i < 6; i++) begin
			wr(`ETW_OFF_COUNT, 0);
			wr(`ETW_OFF_CONTROL, ctl(0, 0, i + 2, 0));
			repeat (4 * divs[i]) @(posedge clk);
			wr(`ETW_OFF_CONTROL, 0);
			apb(`ETW_OFF_COUNT, 0, 0);
			chk(rd >= 4 && rd <= 5, 1);
		end
		// fast and phase correct both give about a quarter duty at compare 0x40
		for (int m = 1; m < 4; m += 2) begin
			wr(`ETW_OFF_COMPARE, 32'h0000_0040);
			wr(`ETW_OFF_COUNT, 0);
			wr(`ETW_OFF_CONTROL, ctl(m, 2, 1, 0));
			repeat (600) @(posedge clk);
			hi = 0;
			repeat (1020) @(posedge clk) hi += pin;
			chk(hi >= 236 && hi <= 280, 1);
			wr(`ETW_OFF_CONTROL, 0);
		end
		// count written equal to compare: the first timer clock after it must not match
		wr(`ETW_OFF_STATUS, 3);
		wr(`ETW_OFF_COMPARE, 32'h0000_0010);
		wr(`ETW_OFF_COUNT, 32'h0000_0010);
		wr(`ETW_OFF_CONTROL, ctl(0, 0, 1, 0));
		wr(`ETW_OFF_CONTROL, 0);
		rdc(`ETW_OFF_STATUS, 0);
		// output mode off: pin follows the port data bit, and the synced pin input reads back
		wr(`ETW_OFF_PORT, 3);
		repeat (3) @(posedge clk);
		chk(pin, 1);
		wr(`ETW_OFF_PORT, 1);
		repeat (3) @(posedge clk);
		chk(pin, 0);
		pin_in <= 1;
		rdc(`ETW_OFF_PORT, 32'h0000_0005);
		final_report;
	end
endmodule
